// ===== common/retry_if.sv
// retry event and limit carrier between engine and retry guard
`timescale 1ns/1ps
interface retry_if;
	logic       retry_evt;
	logic       done_evt;
	logic [7:0] limit;
	logic       timeout;
	modport guard (input retry_evt, input done_evt, input limit, output timeout);
	modport core  (output retry_evt, output done_evt, output limit, input timeout);
endinterface : retry_if

// ===== common/td_pkg.sv
// constants and types shared by the descriptor engine and the retry guard
// ============================================================
// Functional notes
// - the two-bit toggle field takes its toggle from the endpoint carry when its upper bit is 0, else from its lower bit.
// - the toggle picks DATA0 or DATA1 and is updated after each good data packet.
// - each transmission error below count 2 bumps the error counter, and an error at count 2 records the code and retires the descriptor.
// - a transaction with no error clears the error counter to 0.
// - the completion status code always holds the status of the last attempted transaction.
// - the current buffer pointer names the next byte to move, and zero means empty packet or buffer done.
// - the buffer end pointer is only read by hardware and bounds the transfer.
// - a retired descriptor is left by following its next descriptor link; a NEXT write in the same cycle holds the descriptor address instead.
// - a PID check failure is coded 06h and a device timeout 05h.
// - interrupt transactions run only while periodic list enable (bit 2) and isochronous enable (bit 3) are both 1.
// - retries beyond the retry time-out value set the unrecoverable error and host system error flags; default 80h.
// - a retry time-out value of 00h turns the check off, and software should write 00h at start-up.
// - reset restores the retry time-out register to its default.
package td_pkg;
	// ============================================================
	// register map (byte addresses)
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_STATUS  = 8'h04;
	localparam logic [7:0] ADDR_MASK    = 8'h08;
	localparam logic [7:0] ADDR_RETRY   = 8'h0C;
	localparam logic [7:0] ADDR_TDINFO  = 8'h10;
	localparam logic [7:0] ADDR_CURBUF  = 8'h14;
	localparam logic [7:0] ADDR_NEXT    = 8'h18;
	localparam logic [7:0] ADDR_BEND    = 8'h1C;
	localparam logic [7:0] ADDR_TDADDR  = 8'h20;
	// ============================================================
	// control bits
	localparam int CTRL_ARM      = 0;
	localparam int CTRL_PERIODIC = 1;
	localparam int CTRL_PERLIST  = 2;
	localparam int CTRL_ISOEN    = 3;
	// status / mask bits
	localparam int ST_DONE    = 0;
	localparam int ST_HALT    = 1;
	localparam int ST_UNRECOV = 2;
	localparam int ST_SYSERR  = 3;
	localparam int ST_W     = 4;
	// descriptor info fields
	localparam int TI_TOG_LO = 0;
	localparam int TI_ERRS_LO = 2;
	localparam int TI_CODE_LO = 4;
	localparam int TI_CARRY  = 8;
	localparam int TI_HALT   = 9;
	localparam int TI_BUSY   = 10;
	// ============================================================
	// reset values and limits
	localparam logic [7:0] RETRY_DEFAULT = 8'h80;
	localparam logic [7:0] RETRY_OFF     = 8'h00;
	localparam logic [1:0] ERRS_LIMIT    = 2'h2;
	// completion status codes
	localparam logic [3:0] CODE_NOERR   = 4'h0;
	localparam logic [3:0] CODE_CRC     = 4'h1;
	localparam logic [3:0] CODE_NORESP  = 4'h5;
	localparam logic [3:0] CODE_PIDFAIL = 4'h6;
	// transaction results reported by the link
	typedef enum logic [1:0] {
		RES_ACK     = 2'b00,
		RES_PIDFAIL = 2'b01,
		RES_TIMEOUT = 2'b10,
		RES_CRC     = 2'b11
	} link_res_t;
	// pick toggle from carry or from the field
	function automatic logic eff_toggle(input logic [1:0] tog, input logic carry);
		eff_toggle = tog[1] ? tog[0] : carry;
	endfunction : eff_toggle
	// map a failed result onto its status code
	function automatic logic [3:0] res_code(input link_res_t r);
		case (r)
			RES_PIDFAIL: res_code = CODE_PIDFAIL;
			RES_TIMEOUT: res_code = CODE_NORESP;
			RES_CRC:     res_code = CODE_CRC;
			default:     res_code = CODE_NOERR;
		endcase
	endfunction : res_code
endpackage : td_pkg

// ===== dv/link_partner.sv
// far-side model: usb link results and pci retry events
`timescale 1ns/1ps
module link_partner (
	output logic       link_clk,
	output logic       link_valid,
	output logic [1:0] link_res,
	output logic       pci_retry,
	output logic       pci_done
);
	// ============================================================
	// idle levels: link clock stands still between frames
	initial begin
		link_clk = 1'b0;
		link_valid = 1'b0;
		link_res = 2'b00;
		pci_retry = 1'b0;
		pci_done = 1'b0;
	end
	// one result per link clock rise, held 100 ns each side; released lines show the inverse
	task automatic send(input logic [1:0] r, input int gap);
		#(gap);
		link_valid = 1'b1;
		link_res = r;
		#100 link_clk = 1'b1;
		#100 link_clk = 1'b0;
		link_valid = 1'b0;
		link_res = ~r;
	endtask : send
	// n retry edges, then a completed transfer if asked
	task automatic retry(input int n, input logic fin);
		repeat (n) begin
			#100 pci_retry = 1'b1;
			#100 pci_retry = 1'b0;
		end
		if (fin) begin
			#100 pci_done = 1'b1;
			#100 pci_done = 1'b0;
		end
	endtask : retry
endmodule : link_partner

// ===== dv/ohci_td_processing_and_retry_guard_bench.sv
// self-checking bench for the descriptor engine and retry guard
`timescale 1ns/1ps
module ohci_td_processing_and_retry_guard_bench;
	import td_pkg::*;
	localparam int unsigned PKT  = 8;
	localparam logic [31:0] BEND = 32'h1000_0100;
	logic        mclk, reset_n, psel, penable, pwrite, pready, pslverr, er;
	logic        link_clk, link_valid, pci_retry, pci_done, irq, data_pid, sched_en;
	logic [7:0]  paddr;
	logic [3:0]  pstrb;
	logic [1:0]  link_res;
	logic [31:0] pwdata, prdata, rd, lfsr;
	int          n_mismatch, n_tests;
	// bench model of descriptor, control and status
	logic [1:0]  m_tog, m_errs;
	logic [3:0]  m_code, m_st, m_ctrl, m_mask;
	logic        m_carry, m_halt;
	logic [31:0] m_curbuf, m_next, m_tdaddr;

	// ============================================================
	// design and far side
	td_engine #(.PKT_BYTES(PKT)) i_td_engine (.mclk(mclk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.pready(pready), .prdata(prdata), .pslverr(pslverr), .link_clk(link_clk),
		.link_valid(link_valid), .link_res(link_res), .pci_retry(pci_retry),
		.pci_done(pci_done), .irq(irq), .data_pid(data_pid), .sched_en(sched_en));
	link_partner i_link_partner (.link_clk(link_clk), .link_valid(link_valid),
		.link_res(link_res), .pci_retry(pci_retry), .pci_done(pci_done));

	// 40 MHz clock
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk; // core logic keeps no lower clock bound of its own
	end

	// ============================================================
	// expectation helpers
	function automatic logic [31:0] next_rand(input logic [31:0] s);
		next_rand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : next_rand
	function automatic logic [3:0] code_of(input logic [1:0] r);
		code_of = (r == 2'b01) ? 4'h6 : (r == 2'b10) ? 4'h5 : (r == 2'b11) ? 4'h1 : 4'h0;
	endfunction : code_of
	function automatic logic [31:0] info_of();
		info_of = {22'h0, m_halt, 1'b0, m_code, m_errs, m_tog};
	endfunction : info_of

	// ============================================================
	// report, compare and bus tasks
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// one apb transfer; waits for pready under a bound
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) begin
			n_mismatch++;
			tally_and_finish();
		end
		if (w) @(posedge mclk);
	endtask : apb
	task automatic settle(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : settle
	task automatic unhalt();
		m_halt = 1'b0;
		m_errs = 2'd0;
		apb(1'b1, ADDR_TDINFO, info_of() | {23'h0, m_carry, 8'h0});
	endtask : unhalt
	// one link result: update the model, then compare every view of it
	task automatic step(input logic [1:0] r);
		logic ok;
		logic t;
		ok = m_ctrl[0] && !m_halt && (!m_ctrl[1] || (m_ctrl[2] && m_ctrl[3]));
		i_link_partner.send(r, lfsr[4] ? 300 : 0);
		if (ok && r == 2'b00) begin
			t = m_tog[1] ? m_tog[0] : m_carry;
			m_tog = {1'b1, ~t};
			m_carry = ~t;
			m_errs = 2'd0;
			m_code = 4'h0;
			if (m_curbuf + PKT > BEND) begin
				m_curbuf = 32'h0;
				m_tdaddr = m_next;
				m_st[0] = 1'b1;
			end else begin
				m_curbuf = m_curbuf + PKT;
			end
		end else if (ok) begin
			m_code = code_of(r);
			if (m_errs == 2'd2) begin
				m_halt = 1'b1;
				m_st[1:0] = 2'b11;
				m_tdaddr = m_next;
			end else begin
				m_errs = m_errs + 2'd1;
			end
		end
		settle(8);
		apb(1'b0, ADDR_TDINFO, 32'h0);
		check("tdinfo", info_of(), rd & 32'h2FF);
		check("data_pid", {31'h0, m_tog[1] ? m_tog[0] : m_carry}, {31'h0, data_pid});
		apb(1'b0, ADDR_CURBUF, 32'h0);
		check("curbuf", m_curbuf, rd);
		apb(1'b0, ADDR_TDADDR, 32'h0);
		check("tdaddr", m_tdaddr, rd);
		apb(1'b0, ADDR_STATUS, 32'h0);
		check("status", {28'h0, m_st}, rd);
		check("irq", {31'h0, |(m_st & m_mask)}, {31'h0, irq});
		apb(1'b1, ADDR_STATUS, 32'hF);
		m_st = 4'h0;
	endtask : step
	task automatic retry_flags(input logic [31:0] exp);
		settle(6);
		apb(1'b0, ADDR_STATUS, 32'h0);
		check("retry flags", exp, rd & 32'hC);
	endtask : retry_flags

	// ============================================================
	// main sequence
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		pstrb = 4'hF;
		reset_n = 1'b0;
		n_mismatch = 0;
		n_tests = 0;
		lfsr = 32'h9edd;
		{m_tog, m_errs, m_code, m_st, m_ctrl, m_mask, m_carry, m_halt, m_curbuf, m_tdaddr} = '0;
		repeat (2) @(posedge mclk);
		reset_n <= 1'b1;
		apb(1'b0, ADDR_RETRY, 32'h0);
		check("retry default", {24'h0, RETRY_DEFAULT}, rd);
		apb(1'b0, 8'h40, 32'h0);
		check("unmapped", 32'h1, {rd[30:0], er});
		// toggle source for every field and carry combination
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, ADDR_TDINFO, {23'h0, i[2], 6'h0, i[1:0]});
			settle(2);
			check("data_pid", {31'h0, i[1] ? i[0] : i[2]}, {31'h0, data_pid});
		end
		m_tog = 2'b11;
		m_carry = 1'b1;
		m_next = next_rand(lfsr) & 32'hFFFF_FFF0;
		apb(1'b1, ADDR_BEND, BEND);
		apb(1'b1, ADDR_NEXT, m_next);
		m_ctrl = 4'h1;
		apb(1'b1, ADDR_CTRL, 32'h1);
		// fixed error run to retirement, a halted result, then random traffic
		for (int i = 0; i < 24; i++) begin
			lfsr = next_rand(lfsr);
			if (m_halt && i > 3) unhalt();
			m_curbuf = BEND - (lfsr[0] ? 32'd8 : 32'd7);
			apb(1'b1, ADDR_CURBUF, m_curbuf);
			m_mask = lfsr[3:0];
			apb(1'b1, ADDR_MASK, {28'h0, m_mask});
			step(i < 4 ? 2'(i + 1) : lfsr[6:5]);
		end
		// schedule gating for each enable pair of a periodic descriptor
		if (m_halt) unhalt();
		for (int j = 0; j < 4; j++) begin
			m_ctrl = {j[1:0], 2'b11};
			apb(1'b1, ADDR_CTRL, {28'h0, m_ctrl});
			settle(1);
			check("sched_en", {31'h0, j == 3}, {31'h0, sched_en});
			m_curbuf = BEND - 32'd8;
			apb(1'b1, ADDR_CURBUF, m_curbuf);
			step(2'b00);
		end
		apb(1'b0, ADDR_BEND, 32'h0);
		check("bend", BEND, rd);
		// retry limit, count clear at the time-out, and disable
		apb(1'b1, ADDR_MASK, 32'h4); // one mask write, no per-source toggling
		apb(1'b1, ADDR_RETRY, 32'h2);
		i_link_partner.retry(2, 1'b0);
		retry_flags(32'h0);
		i_link_partner.retry(1, 1'b1);
		retry_flags(32'hC);
		check("irq", 32'h1, {31'h0, irq});
		apb(1'b1, ADDR_STATUS, 32'hF);
		settle(2);
		check("irq", 32'h0, {31'h0, irq});
		i_link_partner.retry(2, 1'b0);
		retry_flags(32'h0);
		apb(1'b1, ADDR_RETRY, 32'h0);
		i_link_partner.retry(6, 1'b0);
		retry_flags(32'h0);
		// second reset restores the retry value
		@(posedge mclk);
		reset_n <= 1'b0;
		repeat (2) @(posedge mclk);
		reset_n <= 1'b1;
		apb(1'b0, ADDR_RETRY, 32'h0);
		check("retry reset", {24'h0, RETRY_DEFAULT}, rd);
		tally_and_finish();
	end
endmodule : ohci_td_processing_and_retry_guard_bench

// ===== src/retry_guard.sv
// counts bus retries and flags when they pass the time-out value
`timescale 1ns/1ps
module retry_guard (
	input  wire logic mclk,
	input  wire logic reset_n,
	retry_if.guard    rif
);
	import td_pkg::*;
	logic [8:0] cnt_q;
	logic [8:0] cnt_d;
	logic       to_q;
	wire        enabled = (rif.limit != RETRY_OFF);
	wire        exceed  = enabled && rif.retry_evt && (cnt_q >= {1'b0, rif.limit});
	// ============================================================
	// retry counter
	assign cnt_d = (!enabled || rif.done_evt || exceed) ? 9'h000
	             : (rif.retry_evt ? cnt_q + 9'h001 : cnt_q);
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			cnt_q <= 9'h000;
			to_q  <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			to_q  <= exceed;
		end
	end
	assign rif.timeout = to_q;
endmodule : retry_guard

// ===== src/td_engine.sv
// descriptor processing engine with apb registers and retry guard
`timescale 1ns/1ps
module td_engine #(
	parameter int unsigned PKT_BYTES = 8
) (
	input  wire logic        mclk,
	input  wire logic        reset_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	input  wire logic        link_clk,
	input  wire logic        link_valid,
	input  wire logic [1:0]  link_res,
	input  wire logic        pci_retry,
	input  wire logic        pci_done,
	output logic             irq,
	output logic             data_pid,
	output logic             sched_en
);
	import td_pkg::*;
	// refuse a packet size that the pointer arithmetic cannot serve
	if (PKT_BYTES == 0 || PKT_BYTES > 1023) begin : g_bad_pkt
		$error("PKT_BYTES out of range");
	end
	localparam logic [31:0] PKT_INC = 32'(PKT_BYTES);

	// ============================================================
	// pin synchronisers and edge detection
	logic [5:0] s1_q;
	logic [5:0] s2_q;
	logic [5:0] s3_q;
	wire  [5:0] pins_in = {pci_done, pci_retry, link_res, link_valid, link_clk};
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			s1_q <= 6'h00;
			s2_q <= 6'h00;
			s3_q <= 6'h00;
		end else begin
			s1_q <= pins_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end
	wire       link_rise = s2_q[0] && !s3_q[0];
	wire       res_evt   = link_rise && s2_q[1];
	wire [1:0] res_raw   = s2_q[3:2];
	link_res_t res;
	assign res = link_res_t'(res_raw);

	// ============================================================
	// register state
	logic [3:0]  ctrl_q;
	logic [3:0]  ctrl_d;
	logic [ST_W-1:0] stat_q;
	logic [ST_W-1:0] stat_d;
	logic [ST_W-1:0] mask_q;
	logic [7:0]  retry_q;
	logic [1:0]  tog_q;
	logic [1:0]  tog_d;
	logic [1:0]  errs_q;
	logic [1:0]  errs_d;
	logic [3:0]  code_q;
	logic [3:0]  code_d;
	logic        carry_q;
	logic        carry_d;
	logic        halt_q;
	logic        halt_d;
	logic [31:0] curbuf_q;
	logic [31:0] curbuf_d;
	logic [31:0] next_q;
	logic [31:0] bend_q;
	logic [31:0] tdaddr_q;
	logic [31:0] tdaddr_d;

	// ============================================================
	// apb decode
	wire setup  = psel && !penable;
	wire wr_acc = psel && penable && pready && pwrite;
	wire sel_ctrl   = (paddr == ADDR_CTRL);
	wire sel_status = (paddr == ADDR_STATUS);
	wire sel_mask   = (paddr == ADDR_MASK);
	wire sel_retry  = (paddr == ADDR_RETRY);
	wire sel_tdinfo = (paddr == ADDR_TDINFO);
	wire sel_curbuf = (paddr == ADDR_CURBUF);
	wire sel_next   = (paddr == ADDR_NEXT);
	wire sel_bend   = (paddr == ADDR_BEND);
	wire sel_tdaddr = (paddr == ADDR_TDADDR);
	wire mapped = sel_ctrl | sel_status | sel_mask | sel_retry | sel_tdinfo
	            | sel_curbuf | sel_next | sel_bend | sel_tdaddr;
	wire w_ctrl   = wr_acc && sel_ctrl && pstrb[0];
	wire w_status = wr_acc && sel_status && pstrb[0];
	wire w_mask   = wr_acc && sel_mask && pstrb[0];
	wire w_retry  = wr_acc && sel_retry && pstrb[0];
	wire w_tdinfo = wr_acc && sel_tdinfo && (pstrb[1:0] == 2'b11);
	wire w_curbuf = wr_acc && sel_curbuf && (pstrb == 4'hF);
	wire w_next   = wr_acc && sel_next && (pstrb == 4'hF);
	wire w_bend   = wr_acc && sel_bend && (pstrb == 4'hF);
	wire [31:0] tdinfo_rd = {21'h000000, !halt_q && ctrl_q[CTRL_ARM], halt_q, carry_q,
	                         code_q, errs_q, tog_q};
	wire [31:0] rd_mux = sel_ctrl   ? {28'h0000000, ctrl_q}
	                   : sel_status ? {28'h0000000, stat_q}
	                   : sel_mask   ? {28'h0000000, mask_q}
	                   : sel_retry  ? {24'h000000, retry_q}
	                   : sel_tdinfo ? tdinfo_rd
	                   : sel_curbuf ? curbuf_q
	                   : sel_next   ? next_q
	                   : sel_bend   ? bend_q
	                   : sel_tdaddr ? tdaddr_q : 32'h00000000;

	// ============================================================
	// transaction processing
	wire sched_ok = ctrl_q[CTRL_PERLIST] && ctrl_q[CTRL_ISOEN];
	wire active   = ctrl_q[CTRL_ARM] && !halt_q && (!ctrl_q[CTRL_PERIODIC] || sched_ok);
	wire take     = res_evt && active;
	wire good     = take && (res == RES_ACK);
	wire bad      = take && (res != RES_ACK);
	wire cur_tog  = eff_toggle(tog_q, carry_q);
	wire [31:0] curbuf_adv = curbuf_q + PKT_INC;
	wire buf_done = (curbuf_q == 32'h00000000) || (curbuf_adv > bend_q);
	wire retire_ok  = good && buf_done;
	wire retire_err = bad && (errs_q == ERRS_LIMIT);
	wire retire     = retire_ok || retire_err;

	// next descriptor fields
	always_comb begin
		tog_d    = tog_q;
		carry_d  = carry_q;
		errs_d   = errs_q;
		code_d   = code_q;
		curbuf_d = curbuf_q;
		halt_d   = halt_q;
		tdaddr_d = tdaddr_q;
		if (good) begin
			tog_d   = {1'b1, !cur_tog};
			carry_d = !cur_tog;
			errs_d   = 2'h0;
			code_d   = CODE_NOERR;
			curbuf_d = buf_done ? 32'h00000000 : curbuf_adv;
		end else if (bad) begin
			code_d = res_code(res);
			if (retire_err)
				halt_d = 1'b1;
			else
				errs_d = errs_q + 2'h1;
		end
		if (retire)
			tdaddr_d = next_q;
		if (w_tdinfo) begin
			tog_d   = pwdata[TI_TOG_LO +: 2];
			errs_d  = pwdata[TI_ERRS_LO +: 2];
			code_d  = pwdata[TI_CODE_LO +: 4];
			carry_d = pwdata[TI_CARRY];
			halt_d  = pwdata[TI_HALT];
		end
		if (w_curbuf)
			curbuf_d = pwdata;
		if (w_next)
			tdaddr_d = tdaddr_q;
	end

	// ============================================================
	// retry guard
	retry_if rif ();
	assign rif.retry_evt = s2_q[4] && !s3_q[4];
	assign rif.done_evt  = s2_q[5] && !s3_q[5];
	assign rif.limit     = retry_q;
	retry_guard u_guard (
		.mclk    (mclk),
		.reset_n (reset_n),
		.rif     (rif)
	);

	// status: hardware set wins over write-one-to-clear
	wire [ST_W-1:0] st_set = {rif.timeout, rif.timeout, retire_err, retire};
	wire [ST_W-1:0] st_clr = w_status ? pwdata[ST_W-1:0] : {ST_W{1'b0}};
	assign stat_d = (stat_q & ~st_clr) | st_set;
	// arm drops only when a control write clears it; a halted descriptor chain leaves it set
	assign ctrl_d = w_ctrl ? pwdata[3:0] : ctrl_q;

	// ============================================================
	// registers
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			ctrl_q  <= 4'h0;
			stat_q  <= {ST_W{1'b0}};
			mask_q  <= {ST_W{1'b0}};
			retry_q <= RETRY_DEFAULT;
		end else begin
			ctrl_q <= ctrl_d;
			stat_q <= stat_d;
			if (w_mask)
				mask_q <= pwdata[ST_W-1:0];
			if (w_retry)
				retry_q <= pwdata[7:0];
		end
	end
	// descriptor image
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			tog_q    <= 2'h0;
			errs_q   <= 2'h0;
			code_q   <= CODE_NOERR;
			carry_q  <= 1'b0;
			halt_q   <= 1'b0;
			curbuf_q <= 32'h00000000;
			tdaddr_q <= 32'h00000000;
		end else begin
			tog_q    <= tog_d;
			errs_q   <= errs_d;
			code_q   <= code_d;
			carry_q  <= carry_d;
			halt_q   <= halt_d;
			curbuf_q <= curbuf_d;
			tdaddr_q <= tdaddr_d;
		end
	end
	// link words written only by software
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			next_q <= 32'h00000000;
			bend_q <= 32'h00000000;
		end else begin
			if (w_next)
				next_q <= pwdata;
			if (w_bend)
				bend_q <= pwdata;
		end
	end
	// bus answer and outputs
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			pready   <= 1'b0;
			prdata   <= 32'h00000000;
			pslverr  <= 1'b0;
			irq      <= 1'b0;
			data_pid <= 1'b0;
			sched_en <= 1'b0;
		end else begin
			pready   <= setup;
			prdata   <= setup && !pwrite ? rd_mux : 32'h00000000;
			pslverr  <= setup && !mapped;
			irq      <= |(stat_d & mask_q);
			data_pid <= eff_toggle(tog_d, carry_d);
			sched_en <= (ctrl_d[CTRL_PERLIST] && ctrl_d[CTRL_ISOEN]);
		end
	end

	// ============================================================
	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	property p_tog_src;
		good && !w_tdinfo |=> tog_q == {1'b1, !$past(cur_tog)} && carry_q == !$past(cur_tog);
	endproperty
	a_tog_src: assert property (p_tog_src) else $error("toggle not advanced");
	property p_pid_out;
		##1 1'b1 |-> data_pid == eff_toggle(tog_q, carry_q);
	endproperty
	a_pid_out: assert property (p_pid_out) else $error("pid out of step");
	property p_errs_inc;
		bad && errs_q != ERRS_LIMIT && !w_tdinfo |=> errs_q == $past(errs_q) + 2'h1 && !halt_q;
	endproperty
	a_errs_inc: assert property (p_errs_inc) else $error("error count not bumped");
	property p_errs_clr;
		good && !w_tdinfo |=> errs_q == 2'h0 && code_q == CODE_NOERR;
	endproperty
	a_errs_clr: assert property (p_errs_clr) else $error("error count not cleared");
	property p_code_pid;
		bad && res == RES_PIDFAIL && !w_tdinfo |=> code_q == CODE_PIDFAIL;
	endproperty
	a_code_pid: assert property (p_code_pid) else $error("pid fail code wrong");
	property p_code_last;
		bad && res == RES_TIMEOUT && !w_tdinfo |=> code_q == CODE_NORESP;
	endproperty
	a_code_last: assert property (p_code_last) else $error("timeout code wrong");
	property p_code_crc;
		bad && res == RES_CRC && !w_tdinfo |=> code_q == CODE_CRC;
	endproperty
	a_code_crc: assert property (p_code_crc) else $error("crc code wrong");
	property p_errs_hold;
		retire_err && !w_tdinfo |=> errs_q == ERRS_LIMIT;
	endproperty
	a_errs_hold: assert property (p_errs_hold) else $error("error count moved at retire");
	property p_retire_done;
		retire |=> stat_q[ST_DONE];
	endproperty
	a_retire_done: assert property (p_retire_done) else $error("retire not flagged");
	property p_sched_out;
		##1 1'b1 |-> sched_en == sched_ok;
	endproperty
	a_sched_out: assert property (p_sched_out) else $error("schedule output wrong");
	// bus answer timing
	property p_ready_ans;
		setup |=> pready;
	endproperty
	a_ready_ans: assert property (p_ready_ans) else $error("no ready after setup");
	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
	property p_unmapped;
		setup && !mapped |=> pslverr && prdata == 32'h00000000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
	property p_halt;
		retire_err && !w_tdinfo |=> halt_q && tdaddr_q == $past(next_q) ##1 stat_q[ST_HALT];
	endproperty
	a_halt: assert property (p_halt) else $error("endpoint not halted");
	property p_link;
		retire_ok && !w_curbuf |=> tdaddr_q == $past(next_q) && curbuf_q == 32'h00000000;
	endproperty
	a_link: assert property (p_link) else $error("next link not followed");
	property p_gate;
		ctrl_q[CTRL_PERIODIC] && !sched_ok |-> !take;
	endproperty
	a_gate: assert property (p_gate) else $error("periodic ran ungated");
	property p_bend_ro;
		!w_bend |=> bend_q == $past(bend_q);
	endproperty
	a_bend_ro: assert property (p_bend_ro) else $error("buffer end changed");
	property p_ue;
		rif.timeout |=> stat_q[ST_UNRECOV] && stat_q[ST_SYSERR];
	endproperty
	a_ue: assert property (p_ue) else $error("retry flags not set");
	property p_off;
		retry_q == RETRY_OFF |=> !rif.timeout;
	endproperty
	a_off: assert property (p_off) else $error("disabled guard fired");
	property p_rst_def;
		@(posedge mclk) $rose(reset_n) |-> retry_q == RETRY_DEFAULT;
	endproperty
	a_rst_def: assert property (p_rst_def) else $error("retry default lost");
	c_good:    cover property (good ##[1:50] good);
	c_retire:  cover property (retire_err);
	c_timeout: cover property (rif.timeout);
	c_irq:     cover property ($rose(irq));
	c_gated:   cover property (take && ctrl_q[CTRL_PERIODIC]);
endmodule : td_engine
